// File: hdl/timer_unit_pkg.sv
package timer_unit_pkg;

    // Channel count and counter width.
    localparam int NUM_CH = 8;
    localparam int CNT_W  = 16;

    // Register byte addresses on the APB side.
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_COUNT   = 8'h04;
    localparam logic [7:0] ADDR_MODULO  = 8'h08;
    localparam logic [7:0] ADDR_CH_BASE = 8'h10;
    localparam logic [7:0] ADDR_CH_END  = 8'h50;

    // Global control field positions.
    localparam int CTRL_PS_LSB   = 0;
    localparam int CTRL_SRC_LSB  = 3;
    localparam int CTRL_CENTER   = 5;
    localparam int CTRL_TC_IE    = 6;
    localparam int CTRL_TC_FLAG  = 7;
    localparam int CTRL_MOD_EN   = 8;
    localparam int CTRL_UPDOWN   = 9;
    localparam int CTRL_EXT_LSB  = 10;
    localparam int CTRL_W        = 14;

    // Channel control field positions.
    localparam int CH_MODE_LSB = 0;
    localparam int CH_SEL_LSB  = 2;
    localparam int CH_POL      = 4;
    localparam int CH_IE       = 5;
    localparam int CH_FLAG     = 6;
    localparam int CH_W        = 7;

    // Reset values.
    localparam logic [CTRL_W-1:0] CTRL_RESET   = 14'h0000;
    localparam logic [CH_W-1:0]   CH_RESET     = 7'h00;
    localparam logic [CNT_W-1:0]  MODULO_RESET = 16'hffff;
    localparam logic [CNT_W-1:0]  VALUE_RESET  = 16'h0000;

    // Counter source choices.
    typedef enum logic [1:0] {SRC_OFF, SRC_BUS, SRC_FIXED, SRC_EXT} clk_src_type;

    // Per-channel operating modes.
    typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_EPWM, MODE_SPARE} ch_mode_type;

endpackage

// File: hdl/timer_unit.sv
`timescale 1ns/1ps

// Overview of operation
// - Eight channels: capture, compare or edge PWM.
// - Capture edge: rising, falling, both, none.
// - Compare action: clear, set, toggle, ignore.
// - PWM output polarity is selectable.
// - One bit selects buffered center PWM everywhere.
// - Center PWM disables other channel functions.
// - Counter source: bus, fixed clock, external.
// - Prescaler divides by one to 128.
// - Fixed clock is synchronised before counting.
// - External clock from channel or dedicated pin.
// - 16-bit counter: free, modulo up, up-down.
// - Interrupt per channel plus terminal count.
// - Debug halt freezes all counting.
// - Stop mode freezes counting; captures still occur.
// - Wait mode behaves exactly like run.
// - Capture copies counter and sets flag.
// - Compare match sets flag and acts.
module timer_unit (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // System state.
    input  wire logic        debug_halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    // Clock inputs.
    input  wire logic        fixed_clk_in,
    input  wire logic        ext_clk_in,
    // Channel pins.
    input  wire logic [7:0]  ch_in,
    output logic      [7:0]  ch_out,
    output logic      [7:0]  ch_oe,
    // Interrupt requests.
    output logic      [7:0]  ch_irq,
    output logic             tc_irq
);

    localparam int N = timer_unit_pkg::NUM_CH;
    localparam int W = timer_unit_pkg::CNT_W;

    // Bus phase strobes.
    logic        setup_phase;               // First cycle of a transfer.
    logic        wr_access;                 // Write takes effect here.
    logic        addr_hit;                  // Address maps to a register.
    logic        ch_hit;                    // Address falls in the channel window.
    logic [7:0]  ch_off;                    // Offset inside the channel window.
    logic [2:0]  ch_idx;                    // Channel addressed.

    // Global state.
    logic [timer_unit_pkg::CTRL_W-1:0] ctrl_reg;   // Global control.
    logic [W-1:0] cnt_reg;                  // Counter.
    logic         up_reg;                   // Counting direction, high is up.
    logic [W-1:0] mod_buf_reg;              // Modulo as written.
    logic [W-1:0] mod_reg;                  // Modulo in use.
    logic [6:0]   presc_reg;                // Prescaler counter.
    logic [2:0]   fix_sync_reg;             // Fixed clock synchroniser and edge stage.
    logic         ext_prev_reg;             // Previous external clock sample.
    logic         upd_reg;                  // Counter changed last cycle.
    logic [7:0]   pin_prev_reg;             // Previous channel pin samples.

    // Per-channel state.
    logic [timer_unit_pkg::CH_W-1:0] chc_reg [N];  // Channel control.
    logic [W-1:0] val_buf_reg [N];          // Channel value as written or captured.
    logic [W-1:0] val_reg [N];              // Channel value in use.

    // Derived controls.
    timer_unit_pkg::clk_src_type src;
    logic         center;
    logic         run;
    logic         src_pulse;
    logic         ext_level;
    logic [6:0]   presc_mask;
    logic         tick;
    logic         bidir;
    logic         tc_event;
    logic         load_act;
    logic         cnt_wr;

    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite && addr_hit;
    assign ch_hit      = (paddr >= timer_unit_pkg::ADDR_CH_BASE) &&
                         (paddr <  timer_unit_pkg::ADDR_CH_END);
    assign ch_off      = paddr - timer_unit_pkg::ADDR_CH_BASE;
    assign ch_idx      = ch_off[5:3];
    assign addr_hit    = (paddr[1:0] == 2'h0) &&
                         (ch_hit || paddr == timer_unit_pkg::ADDR_CTRL ||
                          paddr == timer_unit_pkg::ADDR_COUNT ||
                          paddr == timer_unit_pkg::ADDR_MODULO);
    assign cnt_wr      = wr_access && paddr == timer_unit_pkg::ADDR_COUNT;

    // The slave never stalls; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    assign src    = timer_unit_pkg::clk_src_type'(ctrl_reg[timer_unit_pkg::CTRL_SRC_LSB +: 2]);
    assign center = ctrl_reg[timer_unit_pkg::CTRL_CENTER];
    // Wait mode is deliberately not a term here: the timer keeps running in it.
    assign run    = (src != timer_unit_pkg::SRC_OFF) && !debug_halt_mode && !stop_mode;

    // The external clock comes from a channel pin or from the dedicated pin.
    assign ext_level = ctrl_reg[timer_unit_pkg::CTRL_EXT_LSB + 3] ? ext_clk_in
                     : ch_in[ctrl_reg[timer_unit_pkg::CTRL_EXT_LSB +: 3]];

    // Source pulse selection, one cycle per counted source edge.
    always_comb begin
        unique case (src)
            timer_unit_pkg::SRC_BUS:   src_pulse = 1'b1;
            timer_unit_pkg::SRC_FIXED: src_pulse = fix_sync_reg[1] && !fix_sync_reg[2];
            timer_unit_pkg::SRC_EXT:   src_pulse = ext_level && !ext_prev_reg;
            timer_unit_pkg::SRC_OFF:   src_pulse = 1'b0;
        endcase
    end

    // Prescaler tap: tick when the low ps bits of the prescaler are all ones.
    assign presc_mask = 7'((8'h01 << ctrl_reg[timer_unit_pkg::CTRL_PS_LSB +: 3]) - 8'h01);
    assign tick       = run && src_pulse && ((presc_reg & presc_mask) == presc_mask);

    // Up-down counting is used by center PWM and by the modulo up-down option.
    assign bidir = center || (ctrl_reg[timer_unit_pkg::CTRL_MOD_EN] &&
                              ctrl_reg[timer_unit_pkg::CTRL_UPDOWN]);

    // Terminal count: turnaround at the top when counting both ways.
    always_comb begin
        if (!tick) begin
            tc_event = 1'b0;
        end else if (bidir) begin
            tc_event = up_reg && (cnt_reg >= mod_reg);
        end else if (ctrl_reg[timer_unit_pkg::CTRL_MOD_EN]) begin
            tc_event = cnt_reg >= mod_reg;
        end else begin
            tc_event = cnt_reg == 16'hffff;
        end
    end

    // In center mode the buffered values move over only at the bottom of the period or on a counter write,
    // so a period never sees half an update; otherwise they move over at once.
    assign load_act = !center || cnt_wr || (tick && !up_reg && cnt_reg == 16'h0000);

    // Synchroniser and edge sampling; the first stage feeds only the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fix_sync_reg <= 3'h0;
            ext_prev_reg <= 1'b0;
            pin_prev_reg <= 8'h00;
        end else begin
            fix_sync_reg <= {fix_sync_reg[1:0], fixed_clk_in};
            ext_prev_reg <= ext_level;
            pin_prev_reg <= ch_in;
        end
    end

    // Prescaler counter; a counter write also restarts the divider.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= 7'h00;
        end else if (cnt_wr) begin
            presc_reg <= 7'h00;
        end else if (run && src_pulse) begin
            presc_reg <= presc_reg + 7'h01;
        end
    end

    // Counter and direction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
            up_reg  <= 1'b1;
        end else if (cnt_wr) begin
            // Any write clears the counter rather than loading a value.
            cnt_reg <= 16'h0000;
            up_reg  <= 1'b1;
        end else if (tick) begin
            if (bidir && up_reg) begin
                if (cnt_reg >= mod_reg) begin
                    up_reg  <= 1'b0;
                    cnt_reg <= (mod_reg == 16'h0000) ? 16'h0000 : cnt_reg - 16'h0001;
                end else begin
                    cnt_reg <= cnt_reg + 16'h0001;
                end
            end else if (bidir) begin
                if (cnt_reg == 16'h0000) begin
                    up_reg  <= 1'b1;
                    cnt_reg <= (mod_reg == 16'h0000) ? 16'h0000 : 16'h0001;
                end else begin
                    cnt_reg <= cnt_reg - 16'h0001;
                end
            end else begin
                // Free-running wraps naturally; modulo wraps at the modulo value.
                up_reg  <= 1'b1;
                cnt_reg <= tc_event ? 16'h0000 : cnt_reg + 16'h0001;
            end
        end
    end

    // Marks the cycle after the counter moved, when compares are evaluated once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_reg <= 1'b0;
        end else begin
            upd_reg <= tick;
        end
    end

    // Global control; the terminal-count flag clears on a one write, but a new
    // terminal count in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= timer_unit_pkg::CTRL_RESET;
        end else begin
            if (wr_access && paddr == timer_unit_pkg::ADDR_CTRL) begin
                ctrl_reg <= pwdata[timer_unit_pkg::CTRL_W-1:0];
                ctrl_reg[timer_unit_pkg::CTRL_TC_FLAG] <=
                    ctrl_reg[timer_unit_pkg::CTRL_TC_FLAG] && !pwdata[timer_unit_pkg::CTRL_TC_FLAG];
            end
            if (tc_event) begin
                ctrl_reg[timer_unit_pkg::CTRL_TC_FLAG] <= 1'b1;
            end
        end
    end

    // Modulo, buffered in center mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_buf_reg <= timer_unit_pkg::MODULO_RESET;
            mod_reg     <= timer_unit_pkg::MODULO_RESET;
        end else begin
            if (wr_access && paddr == timer_unit_pkg::ADDR_MODULO) begin
                mod_buf_reg <= pwdata[W-1:0];
            end
            if (load_act) begin
                mod_reg <= mod_buf_reg;
            end
        end
    end

    assign tc_irq = ctrl_reg[timer_unit_pkg::CTRL_TC_FLAG] && ctrl_reg[timer_unit_pkg::CTRL_TC_IE];

    // One identical slice per channel.
    for (genvar i = 0; i < N; i++) begin : g_ch
        timer_unit_pkg::ch_mode_type mode;
        logic [1:0] sel;        // Edge select in capture, pin action in compare.
        logic       ch_wr;      // Write to this channel's control.
        logic       val_wr;     // Write to this channel's value.
        logic       rise;
        logic       fall;
        logic       cap_evt;
        logic       match;
        logic       cmp_evt;
        logic       pwm_lvl;

        assign mode    = timer_unit_pkg::ch_mode_type'(chc_reg[i][timer_unit_pkg::CH_MODE_LSB +: 2]);
        assign sel     = chc_reg[i][timer_unit_pkg::CH_SEL_LSB +: 2];
        assign ch_wr   = wr_access && ch_hit && ch_idx == 3'(i) && !paddr[2];
        assign val_wr  = wr_access && ch_hit && ch_idx == 3'(i) && paddr[2];
        assign rise    = ch_in[i] && !pin_prev_reg[i];
        assign fall    = !ch_in[i] && pin_prev_reg[i];
        assign match   = upd_reg && cnt_reg == val_reg[i];
        assign pwm_lvl = (cnt_reg < val_reg[i]) ^ chc_reg[i][timer_unit_pkg::CH_POL];

        // Edge select 00 disables the channel; center mode disables capture.
        assign cap_evt = !center && src != timer_unit_pkg::SRC_OFF &&
                         mode == timer_unit_pkg::MODE_CAPTURE &&
                         ((sel[0] && rise) || (sel[1] && fall));
        // Compare and both PWM forms flag at the match point.
        assign cmp_evt = match && (center || mode == timer_unit_pkg::MODE_COMPARE ||
                                   mode == timer_unit_pkg::MODE_EPWM);

        // Channel control with a set-wins flag.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                chc_reg[i] <= timer_unit_pkg::CH_RESET;
            end else begin
                if (ch_wr) begin
                    chc_reg[i] <= pwdata[timer_unit_pkg::CH_W-1:0];
                    chc_reg[i][timer_unit_pkg::CH_FLAG] <=
                        chc_reg[i][timer_unit_pkg::CH_FLAG] && !pwdata[timer_unit_pkg::CH_FLAG];
                end
                if (cap_evt || cmp_evt) begin
                    chc_reg[i][timer_unit_pkg::CH_FLAG] <= 1'b1;
                end
            end
        end

        // Channel value; a capture overrides a same-cycle write.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                val_buf_reg[i] <= timer_unit_pkg::VALUE_RESET;
                val_reg[i]     <= timer_unit_pkg::VALUE_RESET;
            end else begin
                if (cap_evt) begin
                    val_buf_reg[i] <= cnt_reg;
                end else if (val_wr) begin
                    val_buf_reg[i] <= pwdata[W-1:0];
                end
                if (load_act) begin
                    val_reg[i] <= cap_evt ? cnt_reg : val_buf_reg[i];
                end
            end
        end

        // Pin drive. Compare holds its level between matches; PWM follows the counter.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ch_out[i] <= 1'b0;
                ch_oe[i]  <= 1'b0;
            end else if (center) begin
                ch_out[i] <= pwm_lvl;
                ch_oe[i]  <= 1'b1;
            end else if (mode == timer_unit_pkg::MODE_EPWM) begin
                ch_out[i] <= pwm_lvl;
                ch_oe[i]  <= 1'b1;
            end else if (mode == timer_unit_pkg::MODE_COMPARE) begin
                // Action 00 leaves the pin to general purpose use.
                ch_oe[i] <= sel != 2'h0;
                if (match) begin
                    unique case (sel)
                        2'h1:    ch_out[i] <= 1'b0;
                        2'h2:    ch_out[i] <= 1'b1;
                        2'h3:    ch_out[i] <= !ch_out[i];
                        default: ch_out[i] <= ch_out[i];
                    endcase
                end
            end else begin
                ch_oe[i] <= 1'b0;
            end
        end

        assign ch_irq[i] = chc_reg[i][timer_unit_pkg::CH_FLAG] &&
                           chc_reg[i][timer_unit_pkg::CH_IE];
    end

    // Read data is captured in the setup cycle so it stands through the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase && !pwrite) begin
            if (!addr_hit) begin
                prdata <= 32'h00000000;
            end else if (ch_hit && !paddr[2]) begin
                prdata <= {25'h0000000, chc_reg[ch_idx]};
            end else if (ch_hit) begin
                prdata <= {16'h0000, val_buf_reg[ch_idx]};
            end else if (paddr == timer_unit_pkg::ADDR_CTRL) begin
                prdata <= {18'h00000, ctrl_reg};
            end else if (paddr == timer_unit_pkg::ADDR_COUNT) begin
                prdata <= {16'h0000, cnt_reg};
            end else begin
                prdata <= {16'h0000, mod_buf_reg};
            end
        end
    end

endmodule // timer_unit

// File: tb/timer_unit_asserts.sv
`timescale 1ns/1ps
// Pin-level checks on the timer unit; it sees only the ports of the block.
module timer_unit_asserts (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // APB.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // System state and pins.
    input wire logic        debug_halt_mode,
    input wire logic        stop_mode,
    input wire logic [7:0]  ch_out,
    input wire logic [7:0]  ch_oe,
    input wire logic [7:0]  ch_irq,
    input wire logic        tc_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       wr_now;      // A write completes in this cycle.
    logic       center_reg;  // Shadow of the centre PWM control bit.
    logic [1:0] quiet_reg;   // Frozen cycles without a write, saturating at three.
    assign wr_now = psel && penable && pwrite;
    // Shadow the global control, since the registers are not visible at the pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) center_reg <= 1'b0;
        else if (wr_now && paddr == timer_unit_pkg::ADDR_CTRL) center_reg <= pwdata[5];
    end
    // Writes may legally move pins, so they restart the frozen count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) quiet_reg <= 2'h0;
        else if (!(debug_halt_mode || stop_mode) || wr_now) quiet_reg <= 2'h0;
        else if (quiet_reg != 2'h3) quiet_reg <= quiet_reg + 2'h1;
    end
    AST_PREADY_HIGH: assert property (pready)
        else $error("pready low");
    AST_ERR_ACCESS_ONLY: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    AST_ERR_UNALIGNED: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    AST_ERR_READ_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returns data");
    AST_CH_IRQ_DROP: assert property (|($past(ch_irq) & ~ch_irq) |-> $past(wr_now))
        else $error("channel request dropped without a write");
    AST_TC_IRQ_DROP: assert property ($fell(tc_irq) |-> $past(wr_now))
        else $error("terminal count request dropped without a write");
    AST_FROZEN_PINS: assert property (quiet_reg == 2'h3 |-> $stable(ch_out))
        else $error("pins moved while frozen");
    AST_CENTER_DRIVES_ALL: assert property (center_reg && $past(center_reg) |-> ch_oe == 8'hff)
        else $error("centre mode leaves a pin undriven");
    COV_CENTER: cover property (center_reg && ch_oe == 8'hff);
    COV_TC: cover property ($rose(tc_irq));
    COV_CH: cover property ($rose(|ch_irq));
    COV_ERR: cover property (pslverr);
endmodule // timer_unit_asserts

bind timer_unit timer_unit_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .debug_halt_mode, .stop_mode, .ch_out, .ch_oe,
    .ch_irq, .tc_irq);

// File: tb/pin_side_model.sv
`timescale 1ns/1ps
// Outside world of the timer: drivers on the channel pins and both clock inputs.
module pin_side_model (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Stimulus from the bench.
    input  wire logic [7:0] pin_drv,
    input  wire logic       ext_drv,
    // Timer pins.
    input  wire logic [7:0] ch_out,
    input  wire logic [7:0] ch_oe,
    output logic      [7:0] ch_in,
    output logic            ext_clk_in,
    output logic            fixed_clk_in
);
    logic [2:0] fix_cnt_reg;  // Divider that makes the slow fixed clock.
    // A pin shows the timer's level where it drives, else the outside driver.
    assign ch_in = (ch_out & ch_oe) | (pin_drv & ~ch_oe);
    assign ext_clk_in = ext_drv;
    // The fixed clock runs free at a tenth of the bus rate, so whole windows count exactly.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fix_cnt_reg  <= 3'h0;
            fixed_clk_in <= 1'b0;
        end else if (fix_cnt_reg == 3'h4) begin
            fix_cnt_reg  <= 3'h0;
            fixed_clk_in <= ~fixed_clk_in;
        end else fix_cnt_reg <= fix_cnt_reg + 3'h1;
    end
endmodule // pin_side_model

// File: tb/test_timer_unit.sv
`timescale 1ns/1ps
// Bench: APB driver notes expected reads; a monitor compares each answer.
module test_timer_unit;
    typedef struct {logic [31:0] d; logic e;} note_type;  // Expected data and error.
    localparam logic [7:0]  CTRL_AD  = timer_unit_pkg::ADDR_CTRL;
    localparam logic [7:0]  COUNT_AD = timer_unit_pkg::ADDR_COUNT;
    localparam logic [7:0]  MOD_AD   = timer_unit_pkg::ADDR_MODULO;
    localparam logic [7:0]  CH_AD    = timer_unit_pkg::ADDR_CH_BASE;
    localparam logic [31:0] CFG [3]  = '{32'h148, 32'h348, 32'h368};  // Count modes.
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tc_irq;
    logic        halt, stop, wait_mode, fixed_clk_in, ext_clk_in, ext_drv;
    logic [7:0]  paddr, ch_in, ch_out, ch_oe, ch_irq, pin_drv;
    logic [31:0] pwdata, prdata, seed;
    int          bad_count, cmp_count;
    note_type    exp_q[$];

    timer_unit dut (.debug_halt_mode(halt), .stop_mode(stop), .*);
    pin_side_model pins (.*);

    // Bus clock at 50 MHz.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) bad_count++;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
        exp_q.push_back('{d, e});
        apb(1'b0, a, 32'h0);
    endtask
    // Counting runs for exactly n edges, then halt or stop freezes it again.
    task automatic run(input int n, input logic stp);
        seed = xs(seed);
        @(posedge pclk);
        {halt, stop, wait_mode} <= {2'b00, seed[0]};
        pin_drv[7:4] <= seed[7:4];
        repeat (n) @(posedge pclk);
        {halt, stop} <= {!stp, stp};
    endtask
    // Pulses the dedicated clock pin (pin below zero) or a channel pin n times.
    task automatic pulses(input int n, input int pin);
        @(posedge pclk);
        halt <= 1'b0;
        for (int k = 0; k < 2 * n + 1; k++) begin
            repeat (3) @(posedge pclk);
            if (pin < 0) ext_drv <= k[0] == 0 && k < 2 * n;
            else pin_drv[pin] <= k[0] == 0 && k < 2 * n;
        end
        halt <= 1'b1;
    endtask
    // Each read answer is compared with the oldest expectation.
    always @(posedge pclk) begin : mon
        note_type n;
        if (psel && penable && !pwrite && pready === 1'b1) begin
            n = exp_q.pop_front();
            check("prdata", prdata, n.d);
            check("pslverr", {31'h0, pslverr}, {31'h0, n.e});
        end
    end
    // Watchdog far beyond the few thousand cycles the run needs.
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, halt, stop, wait_mode, ext_drv} = 7'b0001000;
        {presetn, paddr, pwdata, pin_drv} = '0;
        {bad_count, cmp_count} = '0;
        seed = 32'ha0a85893;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(CTRL_AD, 32'h0);
        rd(MOD_AD, 32'hffff);
        rd(CH_AD + 8'h04, 32'h0);
        rd(8'h60, 32'h0, 1'b1);
        rd(8'h05, 32'h0, 1'b1);
        // Every tap gives eight ticks in eight periods, frozen by halt or stop in turn.
        for (int p = 0; p < 8; p++) begin
            wr(CTRL_AD, 32'h08 | 32'(p));
            wr(COUNT_AD, 32'h0);
            run(8 << p, p[0]);
            rd(COUNT_AD, 32'h8);
        end
        // Modulo up, up-down and centre counting, nine ticks to a modulo of five.
        for (int m = 0; m < 3; m++) begin
            wr(MOD_AD, 32'h5);
            wr(CTRL_AD, CFG[m]);
            wr(COUNT_AD, 32'h0);
            run(9, 1'b0);
            rd(COUNT_AD, m == 0 ? 32'h3 : 32'h1);
            rd(CTRL_AD, CFG[m] | 32'h80);
            @(negedge pclk);
            check("tc_irq", {31'h0, tc_irq}, 32'h1);
            wr(CTRL_AD, CFG[m] | 32'h80);
            @(negedge pclk);
            check("tc_irq", {31'h0, tc_irq}, 32'h0);
        end
        wr(CTRL_AD, 32'h10);
        wr(COUNT_AD, 32'h0);
        run(80, 1'b0);
        rd(COUNT_AD, 32'h8);
        for (int x = 0; x < 2; x++) begin
            wr(CTRL_AD, x == 0 ? 32'h2018 : 32'h0818);
            wr(COUNT_AD, 32'h0);
            pulses(3 + x, x == 0 ? -1 : 2);
            rd(COUNT_AD, 32'(3 + x));
        end
        // Channels 0-3 capture on each edge choice, 4-7 compare with each action.
        wr(MOD_AD, 32'hc);
        wr(CTRL_AD, 32'h108);
        for (int i = 0; i < 8; i++) begin
            wr(CH_AD + 8'(8 * i), 32'(i < 4 ? 32 + 4 * i : 4 * i - 15));
            wr(CH_AD + 8'(8 * i + 4), 32'h6);
        end
        wr(COUNT_AD, 32'h0);
        run(20, 1'b0);
        @(negedge pclk);
        check("ch_out", {29'h0, ch_out[7:5]}, 32'h2);
        for (int i = 4; i < 8; i++) rd(CH_AD + 8'(8 * i), 32'(4 * i + 49));
        for (int ph = 0; ph < 2; ph++) begin
            @(posedge pclk);
            pin_drv[3:0] <= ph == 0 ? 4'hf : 4'h0;
            repeat (4) @(negedge pclk);
            check("ch_irq", {24'h0, ch_irq}, ph == 0 ? 32'ha : 32'hc);
            for (int i = 0; i < 4; i++) wr(CH_AD + 8'(8 * i), 32'(96 + 4 * i));
        end
        for (int i = 0; i < 4; i++) rd(CH_AD + 8'(8 * i + 4), i == 0 ? 32'h6 : 32'h7);
        // Edge PWM in both polarities, then centre mode takes every pin.
        wr(CH_AD + 8'h20, 32'h2);
        wr(CH_AD + 8'h28, 32'h12);
        repeat (3) @(negedge pclk);
        check("ch_out", {30'h0, ch_out[5:4]}, 32'h2);
        wr(CTRL_AD, 32'h328);
        repeat (3) @(negedge pclk);
        check("ch_oe", {24'h0, ch_oe}, 32'hff);
        wr(CH_AD + 8'h24, 32'h9);
        repeat (3) @(negedge pclk);
        check("ch_out", {31'h0, ch_out[4]}, 32'h0);
        wr(COUNT_AD, 32'h0);
        repeat (3) @(negedge pclk);
        check("ch_out", {31'h0, ch_out[4]}, 32'h1);
        wr(CTRL_AD, 32'h0);
        run(20, 1'b0);
        rd(COUNT_AD, 32'h0);
        wrap_up();
    end
endmodule // test_timer_unit
